/* File: inc/hms_pkg.sv */
/*
  Constants, register offsets and types for the monitor scan sequencer.
  Assumes a single 100 MHz system clock shared with the serial register logic
  and with the converter front end.
*/
// Notes on behaviour
// - Writing config with init and clear-interrupt low and run high starts scanning.
// - Running: visit each input in fixed order, about once per second, store result.
// - Results are readable at any moment without disturbing the scan.
// - On stop, finish the current pass and store its results, then cease.
// - Every restart after a halt begins with the temperature channel.
// - Latest temperature sits at location 27h as a signed Celsius byte.
// - Temperature byte: sign bit then weights 64 down to 1 degree.
// - Each supply channel stores an unsigned 8-bit code 0 to 255.
// - Positive supplies: nominal voltage reads as code 192, three quarters scale.
// - Positive supply step is nominal over 192, e.g. 62.5, 26.0, 17.2 mV.
// - Core supplies map 0 V to 00h and 3.60 V to FFh, 14.1 mV step.
// - Clearing run stops the loop into standby; register access stays available.
// - Clear-interrupt high holds scanning halted until written low again.
`default_nettype none
package hms_pkg;

  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 8;
  localparam int          CHAN_W        = 3;

  // Register map
  localparam logic [7:0]  ADDR_CONFIG   = 8'h40;
  localparam logic [7:0]  ADDR_TEMP     = 8'h27;
  localparam logic [7:0]  ADDR_VOLT0    = 8'h20;
  localparam logic [7:0]  CONFIG_RESET  = 8'h08;

  // Config field positions
  localparam int          CFG_RUN       = 0;
  localparam int          CFG_INT_EN    = 1;
  localparam int          CFG_INT_CLEAR = 3;
  localparam int          CFG_INIT      = 7;

  // Channels: index 0 is temperature, 1..6 are the six supply inputs
  localparam int          NUM_CHAN      = 7;
  localparam logic [2:0]  CHAN_TEMP     = 3'h0;
  localparam logic [2:0]  CHAN_LAST     = 3'h6;
  localparam logic [7:0]  RESULT_RESET  = 8'h00;

  // Scan pacing: one pass per second
  localparam longint      CLK_HZ        = 100_000_000;
  localparam longint      PASS_TIME_MS  = 1000;
  localparam int          PASS_CYCLES   = int'((PASS_TIME_MS * CLK_HZ) / 1000);
  localparam int          TIMER_W       = 32;

  typedef enum logic [1:0] {
    HMS_IDLE,
    HMS_START,
    HMS_WAIT,
    HMS_PAUSE
  } hms_state_t;

endpackage
`default_nettype wire

/* File: hw/hms_scan_loop.sv */
/*
  Scan sequencer and result memory of the hardware monitor.
  Supply slots 20h..25h hold channels 1..6, temperature sits at 27h and the
  configuration byte reads back at 40h.
  Assumes the serial interface logic on sys_clk presents an internal address
  pointer and config write strobes, and a converter front end on sys_clk that
  answers each start pulse with one done pulse and an 8-bit code. Analog
  scaling of supply codes happens in the front end; this block stores codes.
*/
`timescale 1ns/10ps
`default_nettype none

module hms_scan_loop #(
  parameter int PASS_CYCLES = hms_pkg::PASS_CYCLES
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  // Register access from the serial interface
  input  wire logic [hms_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic                        cfgWrEn,
  input  wire logic [hms_pkg::DATA_W-1:0]  cfgWrData,
  output logic      [hms_pkg::DATA_W-1:0]  regRdData,
  // Converter front end
  output logic                             adcStart,
  output logic      [hms_pkg::CHAN_W-1:0]  adcChannel,
  input  wire logic                        adcDone,
  input  wire logic [hms_pkg::DATA_W-1:0]  adcCode,
  // Status
  output logic                             scanActive,
  output logic                             intEnable
);
  import hms_pkg::*;

  // Reset synchroniser
  logic                 rstMeta;
  logic                 rstSync;

  // Configuration byte
  logic [DATA_W-1:0]    cfgReg;
  logic [DATA_W-1:0]    next_cfgReg;
  logic                 runReq;

  // Sequencer
  hms_state_t           state;
  hms_state_t           next_state;
  logic [CHAN_W-1:0]    chan;
  logic [CHAN_W-1:0]    next_chan;
  logic [TIMER_W-1:0]   timer;
  logic [TIMER_W-1:0]   next_timer;
  logic                 next_adcStart;
  logic                 passDue;

  // Result memory
  logic [DATA_W-1:0]    result [NUM_CHAN];
  logic [DATA_W-1:0]    next_result [NUM_CHAN];
  logic                 resultWrite;

  // Registered outputs
  logic [DATA_W-1:0]    next_regRdData;
  logic [CHAN_W-1:0]    next_adcChannel;
  logic                 next_scanActive;
  logic                 next_intEnable;

  // Reset release through two flip-flops; assertion stays asynchronous so the
  // block resets without a clock, while release is clean to sys_clk
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Config register; initialisation bit restores the default and clears itself.
  // Only init, run, interrupt enable and interrupt clear act in this block; the other
  // bits are kept for the neighbouring reset and intrusion logic.
  // Stored results are not touched by an initialisation.
  always_comb begin
    next_cfgReg = cfgReg;
    if (cfgWrEn) begin
      if (cfgWrData[CFG_INIT]) begin
        next_cfgReg = CONFIG_RESET;
      end else begin
        next_cfgReg = cfgWrData;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      cfgReg <= CONFIG_RESET;
    end else begin
      cfgReg <= next_cfgReg;
    end
  end

  // Run only with run set and interrupt clear low
  assign runReq  = cfgReg[CFG_RUN] && !cfgReg[CFG_INT_CLEAR];
  // The pass timer saturates, so a pass that outlasts the period (slow
  // converter) is followed at once by the next one instead of wrapping
  assign passDue = (timer >= TIMER_W'(PASS_CYCLES - 1));

  // Scan sequencer. Stop requests are only looked at between passes, so a
  // pass once begun always completes and stores every result.
  always_comb begin
    next_state    = state;
    next_chan     = chan;
    next_adcStart = 1'b0;
    next_timer    = passDue ? timer : timer + TIMER_W'(1);
    unique case (state)
      HMS_IDLE: begin
        // Standby: timer held at zero so the second pass of a run starts a full period after the first
        next_timer = '0;
        if (runReq) begin
          next_chan  = CHAN_TEMP;
          next_state = HMS_START;
        end
      end
      HMS_START: begin
        // One-cycle start pulse; the channel already stands on adcChannel
        next_adcStart = 1'b1;
        next_state    = HMS_WAIT;
      end
      HMS_WAIT: begin
        // A done pulse is only taken here; one in any other state is ignored
        if (adcDone) begin
          if (chan == CHAN_LAST) begin
            next_state = runReq ? HMS_PAUSE : HMS_IDLE;
          end else begin
            next_chan  = chan + CHAN_W'(1);
            next_state = HMS_START;
          end
        end
      end
      HMS_PAUSE: begin
        // Hold off the next pass so each channel is visited once per second
        if (!runReq) begin
          next_state = HMS_IDLE;
        end else if (passDue) begin
          next_timer = '0;
          next_chan  = CHAN_TEMP;
          next_state = HMS_START;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      state    <= HMS_IDLE;
      chan     <= CHAN_TEMP;
      timer    <= '0;
      adcStart <= 1'b0;
    end else begin
      state    <= next_state;
      chan     <= next_chan;
      timer    <= next_timer;
      adcStart <= next_adcStart;
    end
  end

  // Result memory: one byte register per channel, always written whole, so
  // a read that races a conversion sees the old or the new code, never a mix.
  // Temperature codes arrive already signed Celsius, supply codes unsigned.
  assign resultWrite = (state == HMS_WAIT) && adcDone;

  for (genvar slot = 0; slot < NUM_CHAN; slot++) begin : gen_slot
    always_comb begin
      next_result[slot] = result[slot];
      if (resultWrite && chan == CHAN_W'(slot)) begin
        next_result[slot] = adcCode;
      end
    end

    always_ff @(posedge sys_clk or negedge rstSync) begin
      if (!rstSync) begin
        result[slot] <= RESULT_RESET;
      end else begin
        result[slot] <= next_result[slot];
      end
    end
  end

  // Read path is independent of the sequencer, so reads never stall a scan.
  // Unmapped addresses read as zero.
  always_comb begin
    next_regRdData = '0;
    if (regAddr == ADDR_TEMP) begin
      next_regRdData = result[CHAN_TEMP];
    end else if (regAddr >= ADDR_VOLT0 && regAddr < ADDR_VOLT0 + 8'(NUM_CHAN - 1)) begin
      next_regRdData = result[CHAN_W'(regAddr - ADDR_VOLT0) + CHAN_W'(1)];
    end else if (regAddr == ADDR_CONFIG) begin
      next_regRdData = cfgReg;
    end
  end

  // Status and channel outputs copy next-state values into flip-flops, so
  // they change on the same edge as the state they describe.
  always_comb begin
    next_adcChannel = next_chan;
    next_scanActive = (next_state != HMS_IDLE);
    next_intEnable  = next_cfgReg[CFG_INT_EN];
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      regRdData  <= '0;
      adcChannel <= '0;
      scanActive <= 1'b0;
      intEnable  <= 1'b0;
    end else begin
      regRdData  <= next_regRdData;
      adcChannel <= next_adcChannel;
      scanActive <= next_scanActive;
      intEnable  <= next_intEnable;
    end
  end

endmodule
`default_nettype wire

/* File: bench/hms_scan_loop_monitor.sv */
/* Port checker for the scan sequencer; assumes one sys_clk domain. */
`timescale 1ns/10ps
`default_nettype none
module hms_scan_loop_monitor
  import hms_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [7:0] regAddr,
  input wire logic       cfgWrEn,
  input wire logic [7:0] cfgWrData,
  input wire logic [7:0] regRdData,
  input wire logic       adcStart,
  input wire logic [2:0] adcChannel,
  input wire logic       adcDone,
  input wire logic [7:0] adcCode,
  input wire logic       scanActive,
  input wire logic       intEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  run_start_a: assert property ((cfgWrData & 8'h89) == 8'h01 && cfgWrEn |-> ##[1:2] scanActive)
    else $error("run write ignored");
  int_enable_a: assert property (cfgWrEn |=> intEnable == (($past(cfgWrData) & 8'h82) == 8'h02))
    else $error("intEnable wrong");
  start_pulse_a: assert property (adcStart |=> !adcStart) else $error("start too wide");
  chan_order_a: assert property (adcDone && adcChannel < CHAN_LAST |=> adcChannel == $past(adcChannel) + 3'h1)
    else $error("channel order");
  temp_first_a: assert property ($rose(scanActive) |=> adcStart && adcChannel == CHAN_TEMP)
    else $error("pass not temp first");
  temp_store_a: assert property (adcDone && adcChannel == CHAN_TEMP && regAddr == ADDR_TEMP
    ##1 regAddr == ADDR_TEMP |=> regRdData == $past(adcCode, 2)) else $error("temp slot stale");
  pass_done_a: assert property (scanActive && adcChannel != CHAN_LAST |=> scanActive)
    else $error("pass cut short");
  idle_quiet_a: assert property (!scanActive |-> !adcStart) else $error("start in standby");
endmodule
bind hms_scan_loop hms_scan_loop_monitor mon (.sys_clk, .reset_n, .regAddr, .cfgWrEn, .cfgWrData,
  .regRdData, .adcStart, .adcChannel, .adcDone, .adcCode, .scanActive, .intEnable);
`default_nettype wire

/* File: bench/hms_adc_model.sv */
/* Converter front end model; assumes one-cycle start pulses on clk. */
`timescale 1ns/10ps
`default_nettype none
module hms_adc_model (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [2:0] chan,
  output logic            done,
  output logic [7:0]      code,
  input  wire logic [7:0] lat,
  input  wire logic [7:0] val [7]
);
  int cnt = 0;
  initial begin
    done = 1'b0;
    code = 8'h00;
  end
  always @(posedge clk) begin
    done <= (cnt == 1);
    // Stale code is inverted so a late sample cannot pass
    code <= (cnt == 1) ? val[chan] : ~code;
    cnt  <= start ? lat : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule
`default_nettype wire

/* File: bench/hms_scan_loop_tb.sv */
/* Bench for the scan sequencer; assumes PASS_CYCLES cut to 200. */
`timescale 1ns/10ps
`default_nettype none
module hms_scan_loop_tb;
  import hms_pkg::*;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic       cfgWrEn = 1'b0;
  logic [7:0] cfgWrData = 8'h00;
  logic [7:0] regRdData, adcCode;
  logic [2:0] adcChannel;
  logic       adcStart, adcDone, scanActive, intEnable;
  logic [7:0] val [7] = '{8'h7d, 8'hc0, 8'h01, 8'hff, 8'h80, 8'h00, 8'h5a};
  logic [7:0] lat = 8'h03;
  int         n_fail = 0;
  int         samples_checked = 0;
  hms_scan_loop #(.PASS_CYCLES(200)) dut (.sys_clk, .reset_n, .regAddr, .cfgWrEn, .cfgWrData,
    .regRdData, .adcStart, .adcChannel, .adcDone, .adcCode, .scanActive, .intEnable);
  hms_adc_model adc (.clk(sys_clk), .start(adcStart), .chan(adcChannel), .done(adcDone),
    .code(adcCode), .lat, .val);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge sys_clk) #1 {cfgWrEn, cfgWrData} = {1'b1, d};
    @(posedge sys_clk) #1 cfgWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) #1 regAddr = a;
    repeat (2) @(posedge sys_clk);
    #1 chk("regRdData", e, regRdData);
  endtask
  task automatic upto(input logic [2:0] ch);
    for (int i = 0; i < 999 && !(adcDone === 1'b1 && adcChannel === ch); i++) @(posedge sys_clk) #1;
  endtask
  task automatic t_first_pass;
    rd(ADDR_TEMP, RESULT_RESET);
    wr(8'h03);
    chk("intEnable", 8'h01, 8'(intEnable));
    upto(CHAN_LAST);
    rd(ADDR_TEMP, 8'h7d);
    for (int k = 1; k < NUM_CHAN; k++) rd(ADDR_VOLT0 + 8'(k - 1), val[k]);
  endtask
  task automatic t_stop_mid;
    lat = 8'h14;
    val[0] = 8'hd8;
    upto(3'h2);
    val[6] = 8'h33;
    wr(8'h00);
    rd(ADDR_TEMP, 8'hd8);
    chk("scanActive", 8'h01, 8'(scanActive));
    upto(CHAN_LAST);
    for (int i = 0; i < 300 && scanActive !== 1'b0; i++) @(posedge sys_clk) #1;
    chk("scanActive", 8'h00, 8'(scanActive));
    rd(ADDR_VOLT0 + 8'h05, 8'h33);
  endtask
  task automatic t_clear_hold;
    wr(8'h09);
    repeat (250) @(posedge sys_clk);
    #1 chk("scanActive", 8'h00, 8'(scanActive));
    rd(ADDR_CONFIG, 8'h09);
    wr(8'h83);
    chk("intEnable", 8'h00, 8'(intEnable));
    rd(ADDR_CONFIG, CONFIG_RESET);
    chk("scanActive", 8'h00, 8'(scanActive));
    wr(8'h01);
    for (int i = 0; i < 9 && adcStart !== 1'b1; i++) @(posedge sys_clk) #1;
    chk("adcStart", 8'h01, 8'(adcStart));
    chk("adcChannel", 8'(CHAN_TEMP), 8'(adcChannel));
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    t_first_pass();
    t_stop_mid();
    t_clear_hold();
    print_verdict();
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
